/* src/rosc_pkg.sv */
// Package for the reset and oscillator mode control block.
// Assumes an APB slave with 32-bit data, one aligned word per register.
package rosc_pkg;
    // Register byte addresses
    localparam logic [7:0] ROSC_ADDR_PUDR = 8'h00;
    localparam logic [7:0] ROSC_ADDR_OSC = 8'h04;
    localparam logic [7:0] ROSC_ADDR_STATUS = 8'h08;
    // Pull-up disable register fields
    localparam int ROSC_PUD_RESET_BIT = 0;
    localparam int ROSC_PUD_BOOT_BIT = 1;
    localparam int ROSC_PUD_MEM_BIT = 2;
    localparam int ROSC_PUD_W = 3;
    localparam logic [ROSC_PUD_W-1:0] ROSC_PUD_RESET_VAL = 3'h0;
    // Oscillator control register fields, no relaxation oscillator controls
    localparam int ROSC_OSC_HL_BIT = 0;
    localparam logic ROSC_OSC_HL_RESET = 1'b0;
    // Status register fields
    localparam int ROSC_ST_BOOT_EXT_BIT = 0;
    localparam int ROSC_ST_EMI20_BIT = 1;
    localparam int ROSC_ST_SECURED_BIT = 2;
    localparam int ROSC_ST_CLK_SRC_BIT = 3;
    localparam int ROSC_ST_MISMATCH_BIT = 4;
    // Reset release delay in internal clocks
    localparam int ROSC_RELEASE_CYCLES = 32;
    localparam int ROSC_CNT_W = 6;
    typedef enum logic [1:0] {
        ROSC_HOLD = 2'b00,
        ROSC_COUNT = 2'b01,
        ROSC_RUN = 2'b11
    } rosc_phase_t;
endpackage : rosc_pkg

/* src/rosc_sync_if.sv */
// Interface carrying reset-release state between the top and the sequencer.
// Assumes one clock domain.
`timescale 1ns/1ps
interface rosc_sync_if;
    logic raw_reset;
    logic por_active;
    logic internal_reset;
    modport seq (input raw_reset, input por_active, output internal_reset);
    modport top (output raw_reset, output por_active, input internal_reset);
endinterface : rosc_sync_if

/* src/rosc_release_seq.sv */
// Reset release sequencer: holds internal reset a fixed count after sources clear.
// Assumes raw_reset is already synchronous to ref_clk.
`timescale 1ns/1ps
module rosc_release_seq #(
    parameter int RELEASE_CYCLES = rosc_pkg::ROSC_RELEASE_CYCLES
) (
    // Clocking
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    // Reset sources and result
    rosc_sync_if.seq sync
);
    import rosc_pkg::*;
    typedef struct packed {
        rosc_phase_t phase;
        logic [ROSC_CNT_W-1:0] cnt;
        logic rst_int;
    } rosc_seq_state_t;
    rosc_seq_state_t st;
    rosc_seq_state_t next_st;
    logic reset_req;
    // Either source restarts the release count
    assign reset_req = sync.raw_reset || sync.por_active;
    always_comb begin
        next_st = st;
        case (st.phase)
            ROSC_HOLD: begin
                next_st.rst_int = 1'b1;
                next_st.cnt = '0;
                if (!reset_req) begin
                    next_st.phase = ROSC_COUNT;
                end
            end
            ROSC_COUNT: begin
                if (reset_req) begin
                    next_st.phase = ROSC_HOLD;
                    next_st.cnt = '0;
                end else if (st.cnt == ROSC_CNT_W'(RELEASE_CYCLES - 1)) begin
                    next_st.phase = ROSC_RUN;
                    next_st.rst_int = 1'b0;
                end else begin
                    next_st.cnt = st.cnt + 1'b1;
                end
            end
            ROSC_RUN: begin
                if (reset_req) begin
                    next_st.phase = ROSC_HOLD;
                    next_st.rst_int = 1'b1;
                end
            end
            default: begin
                next_st.phase = ROSC_HOLD;
                next_st.rst_int = 1'b1;
            end
        endcase
    end
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            st <= '{phase: ROSC_HOLD, cnt: '0, rst_int: 1'b1};
        end else if (clk_en) begin
            st <= next_st;
        end
    end
    assign sync.internal_reset = st.rst_int;
endmodule : rosc_release_seq

/* src/rosc_top.sv */
// Operation
// - External reset low holds device in reset
// - Power-on reset asserts internal reset
// - Reset output follows internal reset
// - Reset pull-up on until software disables
// - Strap high boots external unless secured
// - Boot strap tied low internally
// - Memory mode depends on strap, security; emi_addr20 stays low here since the boot strap is tied low
// - Oscillator select resets to zero
// - No relaxation oscillator controls present
//
// Top of the reset and oscillator mode control block with its APB slave.
// Assumes pin inputs are synchronous to ref_clk; rst_b is the power-on reset.
`timescale 1ns/1ps
module rosc_top #(
    parameter int RELEASE_CYCLES = rosc_pkg::ROSC_RELEASE_CYCLES
) (
    // Clock and power-on reset
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    // External reset and straps
    input wire logic ext_reset_b,
    input wire logic ext_memory_mode_strap,
    input wire logic flash_secured,
    input wire logic clock_source_mode_in,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pin controls and mode outputs
    output logic reset_out_pin,
    output logic reset_pullup_en,
    output logic boot_strap_pullup_en,
    output logic mem_strap_pullup_en,
    output logic osc_range_select_bit,
    output logic internal_reset,
    output logic boot_external,
    output logic emi_addr20
);
    import rosc_pkg::*;
    typedef struct packed {
        logic [ROSC_PUD_W-1:0] pullup_disable_reg;
        logic osc_high_low_sel;
        logic boot_ext;
        logic emi20;
        logic secured;
        logic latched;
        logic [31:0] rdata;
    } rosc_top_state_t;
    rosc_top_state_t st;
    rosc_top_state_t next_st;
    rosc_sync_if sync ();
    logic boot_source_strap;
    logic acc;
    logic hit;
    logic [31:0] rd_mux;
    // Strap is bonded to ground, so the device always boots internally
    assign boot_source_strap = 1'b0;
    // Power-on reset and external reset both feed the sequencer
    assign sync.raw_reset = !ext_reset_b;
    assign sync.por_active = !rst_b;
    rosc_release_seq #(
        .RELEASE_CYCLES(RELEASE_CYCLES)
    ) u_seq (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .sync(sync.seq)
    );
    assign acc = psel && penable;
    assign hit = (paddr == ROSC_ADDR_PUDR) || (paddr == ROSC_ADDR_OSC) || (paddr == ROSC_ADDR_STATUS);
    always_comb begin
        rd_mux = 32'h0;
        case (paddr)
            ROSC_ADDR_PUDR: rd_mux[ROSC_PUD_W-1:0] = st.pullup_disable_reg;
            ROSC_ADDR_OSC: rd_mux[ROSC_OSC_HL_BIT] = st.osc_high_low_sel;
            ROSC_ADDR_STATUS: begin
                rd_mux[ROSC_ST_BOOT_EXT_BIT] = st.boot_ext;
                rd_mux[ROSC_ST_EMI20_BIT] = st.emi20;
                rd_mux[ROSC_ST_SECURED_BIT] = st.secured;
                rd_mux[ROSC_ST_CLK_SRC_BIT] = clock_source_mode_in;
                // Flags an external clock with the select bit still low
                rd_mux[ROSC_ST_MISMATCH_BIT] = clock_source_mode_in && !st.osc_high_low_sel;
            end
            default: rd_mux = 32'h0;
        endcase
    end
    always_comb begin
        next_st = st;
        // Straps are captured once per reset; later security changes wait for next reset
        if (internal_reset) begin
            next_st.pullup_disable_reg = ROSC_PUD_RESET_VAL;
            next_st.osc_high_low_sel = ROSC_OSC_HL_RESET;
            next_st.latched = 1'b0;
        end else if (!st.latched) begin
            next_st.latched = 1'b1;
            next_st.secured = flash_secured;
            next_st.boot_ext = boot_source_strap && !flash_secured;
            next_st.emi20 = boot_source_strap && !flash_secured && ext_memory_mode_strap;
        end
        if (!internal_reset && acc && pwrite) begin
            if (paddr == ROSC_ADDR_PUDR) begin
                next_st.pullup_disable_reg = pwdata[ROSC_PUD_W-1:0];
            end
            if (paddr == ROSC_ADDR_OSC) begin
                next_st.osc_high_low_sel = pwdata[ROSC_OSC_HL_BIT];
            end
        end
        // Captured in the setup cycle, so read data leaves a flop with no wait state
        if (psel && !penable) begin
            next_st.rdata = rd_mux;
        end
    end
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            st <= '0;
        end else if (clk_en) begin
            st <= next_st;
        end
    end
    // Single-cycle access phase; unmapped addresses raise pslverr and read zero
    assign pready = 1'b1;
    assign pslverr = acc && !hit;
    assign prdata = st.rdata;
    assign internal_reset = !rst_b || sync.internal_reset;
    assign reset_out_pin = internal_reset;
    assign reset_pullup_en = !st.pullup_disable_reg[ROSC_PUD_RESET_BIT];
    assign boot_strap_pullup_en = !st.pullup_disable_reg[ROSC_PUD_BOOT_BIT];
    assign mem_strap_pullup_en = !st.pullup_disable_reg[ROSC_PUD_MEM_BIT];
    assign osc_range_select_bit = st.osc_high_low_sel;
    assign boot_external = st.boot_ext;
    assign emi_addr20 = st.emi20;
endmodule : rosc_top

/* verification/rosc_board.sv */
// Board model: external reset source, debug reset and clock source select.
// Assumes requests arrive just after rising edges of ref_clk.
`timescale 1ns/1ps
module rosc_board (
    // Clock and requests
    input wire logic ref_clk,
    input wire logic go,
    input wire logic [7:0] hold,
    input wire logic ext_clk,
    // Board pins
    output logic ext_reset_b,
    output logic trst_b,
    output logic clock_source_mode_in
);
    logic [7:0] left = 8'h00;
    always @(posedge ref_clk) left <= go ? hold : left - {7'h0, left != 8'h00};
    assign ext_reset_b = left == 8'h00;
    assign trst_b = ext_reset_b; // Full reset, debug side too
    assign clock_source_mode_in = ext_clk;
endmodule : rosc_board

/* verification/rosc_top_monitor.sv */
// Checker for the reset and oscillator mode block, top ports only.
// Assumes clk_en is held high; bound into rosc_top below.
`timescale 1ns/1ps
module rosc_top_monitor #(
    parameter int RELEASE_CYCLES = rosc_pkg::ROSC_RELEASE_CYCLES
) (
    // Clock and resets
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic ext_reset_b,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    // Outputs
    input wire logic reset_out_pin,
    input wire logic reset_pullup_en,
    input wire logic boot_strap_pullup_en,
    input wire logic mem_strap_pullup_en,
    input wire logic osc_range_select_bit,
    input wire logic internal_reset,
    input wire logic boot_external,
    input wire logic emi_addr20
);
    logic [5:0] quiet;
    logic ext_d;
    logic wr;
    assign wr = psel && penable && pwrite && !internal_reset;
    // Extra stage tolerates a pin synchroniser; saturates so it never wraps
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ext_d <= 1'b0;
            quiet <= 6'h00;
        end else begin
            ext_d <= ext_reset_b;
            quiet <= (!ext_reset_b || !ext_d) ? 6'h00 : quiet + {5'h0, quiet != 6'h3f};
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    AST_POR: assert property (disable iff (1'b0) !rst_b |-> internal_reset) else $error("no reset in por");
    AST_EXT_HOLD: assert property (!ext_reset_b [*2] |=> internal_reset) else $error("ext reset lost");
    AST_REL_EARLY: assert property (quiet < RELEASE_CYCLES |-> internal_reset) else $error("early release");
    AST_REL_LATE: assert property (quiet == RELEASE_CYCLES + 4 |-> !internal_reset) else $error("late release");
    AST_RST_OUT: assert property (reset_out_pin == internal_reset) else $error("reset out differs");
    AST_BOOT: assert property (!internal_reset |-> !boot_external && !emi_addr20)
        else $error("boot not internal");
    AST_DEFAULTS: assert property (internal_reset [*2] |-> reset_pullup_en && boot_strap_pullup_en
        && mem_strap_pullup_en && !osc_range_select_bit) else $error("defaults lost in reset");
    AST_PUD_WR: assert property (wr && paddr == 8'h00 |=>
        {mem_strap_pullup_en, boot_strap_pullup_en, reset_pullup_en} == ~$past(pwdata[2:0])) else $error("pud lost");
    AST_OSC_WR: assert property (wr && paddr == 8'h04 |=> osc_range_select_bit == $past(pwdata[0]))
        else $error("osc write lost");
endmodule : rosc_top_monitor
bind rosc_top rosc_top_monitor #(.RELEASE_CYCLES(RELEASE_CYCLES)) u_mon (.ref_clk(ref_clk), .rst_b(rst_b),
    .ext_reset_b(ext_reset_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .reset_out_pin(reset_out_pin), .reset_pullup_en(reset_pullup_en), .boot_strap_pullup_en(boot_strap_pullup_en),
    .mem_strap_pullup_en(mem_strap_pullup_en), .osc_range_select_bit(osc_range_select_bit),
    .internal_reset(internal_reset), .boot_external(boot_external), .emi_addr20(emi_addr20));

/* verification/rosc_top_bench.sv */
// Self-checking bench for the reset and oscillator mode block.
// Assumes the board model drives the reset pin and clock mode input.
`timescale 1ns/1ps
module rosc_top_bench;
    import rosc_pkg::*;
    localparam int RC = 4;
    logic ref_clk, rst_b, psel, penable, pwrite, sec, mem, go, ext_clk, pready, err, ro, pr, pb, pm, osc, ir, be, em;
    logic ext_reset_b, cm, slverr;
    logic [7:0] paddr, hold;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] s;
    int n_fail = 0, n_tests = 0, n;
    rosc_top #(.RELEASE_CYCLES(RC)) DUT (.ref_clk(ref_clk), .rst_b(rst_b), .clk_en(1'b1), .ext_reset_b(ext_reset_b),
        .ext_memory_mode_strap(mem), .flash_secured(sec), .clock_source_mode_in(cm), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(slverr),
        .reset_out_pin(ro), .reset_pullup_en(pr), .boot_strap_pullup_en(pb), .mem_strap_pullup_en(pm),
        .osc_range_select_bit(osc), .internal_reset(ir), .boot_external(be), .emi_addr20(em));
    rosc_board BOARD (.ref_clk(ref_clk), .go(go), .hold(hold), .ext_clk(ext_clk), .ext_reset_b(ext_reset_b),
        .trst_b(), .clock_source_mode_in(cm));
    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : lfsr
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // Entered just after an edge; holds the request until pready is seen
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        // No cycle count assumed; only the watchdog ends a stuck wait
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = slverr;
        {psel, penable} <= 2'b00;
        @(posedge ref_clk);
    endtask : apb
    // Counts enabled edges from the request's removal to the release
    task automatic settle();
        n = 0;
        @(negedge ref_clk);
        while (ir !== 1'b0 && n < 300) begin
            @(negedge ref_clk);
            n++;
        end
        chk("reset released", 32'h0, {31'h0, ir});
        @(posedge ref_clk);
    endtask : settle
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : end_sim
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_fail++;
        end_sim();
    end
    initial begin
        s = 16'ha88e;
        {rst_b, psel, penable, pwrite, go, ext_clk, mem, paddr, pwdata, hold} = '0;
        sec = s[1];
        repeat (20) @(posedge ref_clk);
        rst_b <= 1'b1;
        settle();
        chk("por release", RC + 1, n);
        chk("pins", 32'h38, {ro, pr, pb, pm, osc, be, em});
        for (int i = 0; i < 24; i++) begin
            s = lfsr(s);
            mem <= s[5];
            ext_clk <= s[4];
            apb(1'b1, ROSC_ADDR_PUDR, {16'h0, s});
            apb(1'b1, ROSC_ADDR_OSC, {31'h0, s[3]});
            apb(1'b0, ROSC_ADDR_PUDR, 32'h0);
            chk("pud", {29'h0, s[2:0]}, rd);
            chk("pullups", {29'h0, ~s[2:0]}, {pm, pb, pr});
            apb(1'b1, ROSC_ADDR_STATUS, 32'hffffffff);
            apb(1'b0, ROSC_ADDR_OSC, 32'h0);
            chk("osc", {31'h0, s[3]}, rd);
            apb(1'b0, ROSC_ADDR_STATUS, 32'h0);
            chk("status", {27'h0, s[4] & ~s[3], s[4], sec, 2'b00}, rd);
            apb(s[6], {s[15:10] | 6'h03, 2'b00}, 32'h0);
            chk("unmapped", 32'h1, {rd[30:0], err});
        end
        apb(1'b1, ROSC_ADDR_PUDR, 32'h7);
        apb(1'b1, ROSC_ADDR_OSC, 32'h1);
        hold <= 8'h03 + {4'h0, s[3:0]};
        go <= 1'b1;
        @(posedge ref_clk);
        go <= 1'b0;
        repeat (3) @(posedge ref_clk);
        chk("ext held", 32'h3, {ir, ro});
        chk("ext defaults", 32'h78, {ro, pr, pb, pm, osc, be, em});
        settle();
        apb(1'b0, ROSC_ADDR_PUDR, 32'h0);
        chk("pud after ext", 32'h0, rd);
        apb(1'b0, ROSC_ADDR_OSC, 32'h0);
        chk("osc after ext", 32'h0, rd);
        end_sim();
    end
endmodule : rosc_top_bench
